// >>> timer16_core.sv
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`include "timer16_map.svh"
// Operation
// - Select 110 counts falling external pin edges, 111 counts rising ones.
// - Force bits act only while the waveform mode is a non-PWM mode.
// - Writing one to a force bit forces a match; output follows its action.
// - A forced match raises no interrupt and never clears the counter.
// - Force bits always read back as zero.
// - Each 16-bit register is a byte pair, high byte at base plus one.
// - One shared 8-bit high-byte latch makes both bytes move together.
// - A counter write suppresses every compare match on the next timer tick.
// - A capture event loads the capture register with the counter value.
// - The capture register can serve as counter top in modes selecting it.
// - Compare registers are continuously compared; a match flags and drives output.
// - Clock select zero stops the counter.
// - While capture is top, the capture input is ignored.
module timer16_core
    import timer16_pkg::*;
#(
    parameter int CNT_WIDTH = 16
) (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       reset_n_in,
    // Register port
    input  wire logic [7:0] addr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic       wr_in,
    input  wire logic       rd_in,
    output logic      [7:0] rdata_out,
    // Timer pins
    input  wire logic       external_count_pin_in,
    input  wire logic       capture_input_pin_in,
    input  wire logic       analog_comp_in,
    output logic            waveform_out_a,
    output logic            waveform_out_b,
    // Interrupt
    output logic            irq_out
);
    if (CNT_WIDTH != 16) begin : g_chk
        $error("CNT_WIDTH must be 16: two bytes through one 8-bit latch");
    end

    // Byte-pair hit: low byte at base, high byte at base plus one
    function automatic logic hit_lo(input logic [7:0] a, input logic [7:0] base);
        return a == base;
    endfunction : hit_lo

    function automatic logic hit_hi(input logic [7:0] a, input logic [7:0] base);
        return a == (base + `OFS_HIGH);
    endfunction : hit_hi

    // Top value per waveform mode; capture register in 8, 10, 12, 14
    function automatic logic [15:0] top_of(input wave_mode_t m,
                                          input logic [15:0] cmp_a,
                                          input logic [15:0] cap);
        unique case (m)
            4'h1, 4'h5:             return `TOP_8BIT;
            4'h2, 4'h6:             return `TOP_9BIT;
            4'h3, 4'h7:             return `TOP_10BIT;
            4'h4, 4'h9, 4'hb, 4'hf: return cmp_a;
            4'h8, 4'ha, 4'hc, 4'he: return cap;
            default:                return `TOP_MAX;
        endcase
    endfunction : top_of

    // Next level of a waveform output on a match
    function automatic logic act_on(input logic cur, input logic [1:0] act);
        unique case (cmp_action_e'(act))
            ACT_TOGGLE: return !cur;
            ACT_CLEAR:  return 1'b0;
            ACT_SET:    return 1'b1;
            ACT_NONE:   return cur;
        endcase
    endfunction : act_on

    // Registers
    logic [7:0]  ctrl_a_r;
    logic [7:0]  ctrl_b_r;
    logic [15:0] count_r,   count_nxt;
    logic [15:0] capture_r, capture_nxt;
    logic [15:0] cmp_a_r,   cmp_a_nxt;
    logic [15:0] cmp_b_r,   cmp_b_nxt;
    logic [7:0]  temp_r,    temp_nxt;
    logic [7:0]  status_r,  status_nxt;
    logic [7:0]  mask_r;
    logic [7:0]  rdata_nxt;
    logic        block_r;
    logic        cap_prev_r;
    logic        wave_a_r;
    logic        wave_b_r;

    // Decodes
    wire logic        tick;
    wire wave_mode_t  mode      = {ctrl_b_r[`FLD_MODE_HI], ctrl_a_r[`FLD_MODE_LO]};
    wire logic        is_pwm    = !(mode == 4'h0 || mode == 4'h4 ||
                                    mode == 4'hc || mode == 4'hd);
    wire logic [15:0] top_val   = top_of(mode, cmp_a_r, capture_r);
    wire logic        cap_top   = (mode == 4'h8) || (mode == 4'ha) ||
                                  (mode == 4'hc) || (mode == 4'he);
    wire logic        wr_cnt_lo = wr_in && hit_lo(addr_in, `OFS_COUNT);
    wire logic        wr_cap_lo = wr_in && hit_lo(addr_in, `OFS_CAPTURE);
    wire logic        wr_a_lo   = wr_in && hit_lo(addr_in, `OFS_CMP_A);
    wire logic        wr_b_lo   = wr_in && hit_lo(addr_in, `OFS_CMP_B);
    wire logic        wr_any_hi = wr_in && (hit_hi(addr_in, `OFS_COUNT) ||
                                  hit_hi(addr_in, `OFS_CAPTURE) ||
                                  hit_hi(addr_in, `OFS_CMP_A) ||
                                  hit_hi(addr_in, `OFS_CMP_B));
    wire logic        wr_ctrl_c = wr_in && (addr_in == `OFS_CTRL_C);
    wire logic [15:0] wr_word   = {temp_r, wdata_in};

    // Force strobes only in non-PWM modes; they never touch the flags
    wire logic force_a = wr_ctrl_c && wdata_in[`BIT_FORCE_A] && !is_pwm;
    wire logic force_b = wr_ctrl_c && wdata_in[`BIT_FORCE_B] && !is_pwm;

    // Real compare matches, removed on the tick after a counter write
    wire logic at_top  = (count_r == top_val);
    wire logic match_a = tick && !block_r && (count_r == cmp_a_r);
    wire logic match_b = tick && !block_r && (count_r == cmp_b_r);

    // Capture source and edge; pin is cut off while capture is top
    wire logic cap_src  = ctrl_b_r[`BIT_COMP_SEL] ? analog_comp_in
                                                  : capture_input_pin_in;
    wire logic cap_edge = ctrl_b_r[`BIT_EDGE_SEL] ? (cap_src && !cap_prev_r)
                                                  : (!cap_src && cap_prev_r);
    wire logic cap_ev   = cap_edge && !cap_top;

    // Timer clock enable from the divider or the external pin
    timer16_prescaler #(
        .DIV_WIDTH (10)
    ) u_prescaler (
        .clk_in                 (clk_in),
        .reset_n_in             (reset_n_in),
        .clock_source_select_in (clk_sel_e'(ctrl_b_r[`FLD_CLK_SEL])),
        .external_count_pin_in  (external_count_pin_in),
        .tick_out               (tick)
    );

    // Counter: a CPU write wins over the tick, wrap at the mode's top
    assign count_nxt = wr_cnt_lo   ? wr_word :
                       !tick       ? count_r :
                       at_top      ? `RST_WORD :
                                     count_r + 16'h0001;

    // Capture: a pin event wins over a CPU write
    assign capture_nxt = cap_ev    ? count_r :
                         wr_cap_lo ? wr_word : capture_r;
    assign cmp_a_nxt   = wr_a_lo   ? wr_word : cmp_a_r;
    assign cmp_b_nxt   = wr_b_lo   ? wr_word : cmp_b_r;

    // Shared latch: high writes park here, low reads fill it
    assign temp_nxt = wr_any_hi ? wdata_in :
                      !rd_in    ? temp_r :
                      hit_lo(addr_in, `OFS_COUNT)   ? count_r[15:8] :
                      hit_lo(addr_in, `OFS_CAPTURE) ? capture_r[15:8] :
                      hit_lo(addr_in, `OFS_CMP_A)   ? cmp_a_r[15:8] :
                      hit_lo(addr_in, `OFS_CMP_B)   ? cmp_b_r[15:8] : temp_r;

    // Status: hardware set wins over a write-one clear in the same cycle
    wire logic [7:0] st_set = {2'b00, cap_ev, 2'b00, match_b, match_a,
                               tick && at_top};
    wire logic [7:0] st_clr = (wr_in && addr_in == `OFS_STATUS) ? wdata_in : 8'h00;
    assign status_nxt = ((status_r & ~st_clr) | st_set) & `STATUS_USED;

    // Read mux; force bits and unused status and mask bits read as zero
    assign rdata_nxt =
        !rd_in                            ? 8'h00 :
        (addr_in == `OFS_CTRL_A)          ? ctrl_a_r :
        (addr_in == `OFS_CTRL_B)          ? ctrl_b_r :
        (addr_in == `OFS_CTRL_C)          ? 8'h00 :
        (addr_in == `OFS_STATUS)          ? status_r :
        (addr_in == `OFS_MASK)            ? mask_r :
        hit_lo(addr_in, `OFS_COUNT)       ? count_r[7:0] :
        hit_lo(addr_in, `OFS_CAPTURE)     ? capture_r[7:0] :
        hit_lo(addr_in, `OFS_CMP_A)       ? cmp_a_r[7:0] :
        hit_lo(addr_in, `OFS_CMP_B)       ? cmp_b_r[7:0] :
        (hit_hi(addr_in, `OFS_COUNT) || hit_hi(addr_in, `OFS_CAPTURE) ||
         hit_hi(addr_in, `OFS_CMP_A) || hit_hi(addr_in, `OFS_CMP_B)) ? temp_r :
        8'h00;

    // 16-bit values and the latch
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            count_r   <= `RST_WORD;
            capture_r <= `RST_WORD;
            cmp_a_r   <= `RST_WORD;
            cmp_b_r   <= `RST_WORD;
            temp_r    <= `RST_BYTE;
        end else begin
            count_r   <= count_nxt;
            capture_r <= capture_nxt;
            cmp_a_r   <= cmp_a_nxt;
            cmp_b_r   <= cmp_b_nxt;
            temp_r    <= temp_nxt;
        end
    end

    // Control, mask, status and read data
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctrl_a_r  <= `RST_BYTE;
            ctrl_b_r  <= `RST_BYTE;
            mask_r    <= `RST_BYTE;
            status_r  <= `RST_BYTE;
            rdata_out <= `RST_BYTE;
        end else begin
            if (wr_in && addr_in == `OFS_CTRL_A) ctrl_a_r <= wdata_in;
            if (wr_in && addr_in == `OFS_CTRL_B) ctrl_b_r <= wdata_in;
            if (wr_in && addr_in == `OFS_MASK) mask_r <= wdata_in & `STATUS_USED;
            status_r  <= status_nxt;
            rdata_out <= rdata_nxt;
        end
    end

    // Match blocking: armed by a counter write, spent on the next tick
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            block_r <= 1'b0;
        end else if (wr_cnt_lo) begin
            block_r <= 1'b1;
        end else if (tick) begin
            block_r <= 1'b0;
        end
    end

    // Capture edge history; held through reset at a fixed level
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cap_prev_r <= 1'b0;
        end else begin
            cap_prev_r <= cap_src;
        end
    end

    // Waveform outputs move on real or forced matches per their action
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wave_a_r <= 1'b0;
            wave_b_r <= 1'b0;
        end else begin
            if (match_a || force_a) wave_a_r <= act_on(wave_a_r, ctrl_a_r[`FLD_ACT_A]);
            if (match_b || force_b) wave_b_r <= act_on(wave_b_r, ctrl_a_r[`FLD_ACT_B]);
        end
    end

    assign waveform_out_a = wave_a_r;
    assign waveform_out_b = wave_b_r;
    // Level interrupt while any unmasked flag stands
    assign irq_out = |(status_r & mask_r);

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    property p_stopped;
        (ctrl_b_r[`FLD_CLK_SEL] == 3'h0) && !wr_cnt_lo |=> $stable(count_r);
    endproperty
    a_stopped: assert property (p_stopped) else $error("counter moved while stopped");

    property p_force_zero;
        rd_in && (addr_in == `OFS_CTRL_C) |=> (rdata_out == 8'h00);
    endproperty
    a_force_zero: assert property (p_force_zero) else $error("force bits read non-zero");

    property p_force_pwm;
        wr_ctrl_c && wdata_in[`BIT_FORCE_A] && is_pwm && !match_a |=> $stable(wave_a_r);
    endproperty
    a_force_pwm: assert property (p_force_pwm) else $error("force acted in a PWM mode");

    property p_force_toggle;
        force_a && !match_a && (ctrl_a_r[`FLD_ACT_A] == 2'h1)
            |=> (wave_a_r != $past(wave_a_r));
    endproperty
    a_force_toggle: assert property (p_force_toggle) else $error("forced toggle lost");

    property p_force_quiet;
        force_a && !match_a && !status_r[`BIT_ST_MATCH_A] && !wr_cnt_lo
            |=> !status_r[`BIT_ST_MATCH_A] && (count_r == $past(count_nxt));
    endproperty
    a_force_quiet: assert property (p_force_quiet) else $error("force raised a flag");

    property p_commit;
        wr_in && hit_hi(addr_in, `OFS_CMP_A) ##1 wr_a_lo
            |=> (cmp_a_r == {$past(wdata_in, 2), $past(wdata_in)});
    endproperty
    a_commit: assert property (p_commit) else $error("byte pair not committed together");

    property p_block_wave;
        block_r && tick && !force_a && !force_b |=> $stable(wave_a_r) && $stable(wave_b_r);
    endproperty
    a_block_wave: assert property (p_block_wave) else $error("blocked match moved an output");

    property p_block_flag;
        block_r && tick && !status_r[`BIT_ST_MATCH_A] && !status_r[`BIT_ST_MATCH_B]
            |=> !status_r[`BIT_ST_MATCH_A] && !status_r[`BIT_ST_MATCH_B];
    endproperty
    a_block_flag: assert property (p_block_flag) else $error("match not blocked");

    property p_capture;
        cap_ev |=> (capture_r == $past(count_r)) && status_r[`BIT_ST_CAPTURE];
    endproperty
    a_capture: assert property (p_capture) else $error("capture missed counter value");

    property p_cap_off;
        cap_top && !wr_cap_lo |=> $stable(capture_r);
    endproperty
    a_cap_off: assert property (p_cap_off) else $error("capture moved while it is top");

    property p_cap_top;
        (mode == 4'hc) && tick && !wr_cnt_lo && (count_r == capture_r)
            |=> (count_r == 16'h0000);
    endproperty
    a_cap_top: assert property (p_cap_top) else $error("capture top did not wrap");

    property p_match;
        tick && !block_r && (count_r == cmp_b_r) |=> status_r[`BIT_ST_MATCH_B];
    endproperty
    a_match: assert property (p_match) else $error("compare match not flagged");

    c_force:   cover property (force_a ##1 force_b);
    c_capture: cover property (cap_ev ##1 rd_in && hit_lo(addr_in, `OFS_CAPTURE));
    c_block:   cover property (wr_cnt_lo ##[1:20] (tick && block_r));
    c_irq:     cover property ($rose(irq_out));
endmodule : timer16_core

// >>> timer16_map.svh
`ifndef TIMER16_MAP_SVH
`define TIMER16_MAP_SVH
// Register offsets (byte addresses)
`define OFS_CTRL_A      8'ha0
`define OFS_CTRL_B      8'ha1
`define OFS_CTRL_C      8'ha2
`define OFS_COUNT       8'ha4
`define OFS_CAPTURE     8'ha6
`define OFS_CMP_A       8'ha8
`define OFS_CMP_B       8'haa
`define OFS_STATUS      8'hb0
`define OFS_MASK        8'hb1
`define OFS_HIGH        8'h01
// Field positions
`define FLD_ACT_A       7:6
`define FLD_ACT_B       5:4
`define FLD_MODE_LO     1:0
`define BIT_EDGE_SEL    6
`define BIT_COMP_SEL    5
`define FLD_MODE_HI     4:3
`define FLD_CLK_SEL     2:0
`define BIT_FORCE_A     7
`define BIT_FORCE_B     6
`define BIT_ST_OVF      0
`define BIT_ST_MATCH_A  1
`define BIT_ST_MATCH_B  2
`define BIT_ST_CAPTURE  5
`define STATUS_USED     8'h27
// Reset values
`define RST_BYTE        8'h00
`define RST_WORD        16'h0000
// Counter tops
`define TOP_MAX         16'hffff
`define TOP_8BIT        16'h00ff
`define TOP_9BIT        16'h01ff
`define TOP_10BIT       16'h03ff
// Prescaler masks: tick when the masked divider bits are all one
`define DIV_MASK_8      10'h007
`define DIV_MASK_64     10'h03f
`define DIV_MASK_256    10'h0ff
`define DIV_MASK_1024   10'h3ff
`endif

// >>> timer16_pkg.sv
package timer16_pkg;
    typedef enum logic [2:0] {
        CS_STOP     = 3'h0,
        CS_DIV1     = 3'h1,
        CS_DIV8     = 3'h2,
        CS_DIV64    = 3'h3,
        CS_DIV256   = 3'h4,
        CS_DIV1024  = 3'h5,
        CS_EXT_FALL = 3'h6,
        CS_EXT_RISE = 3'h7
    } clk_sel_e;
    typedef enum logic [1:0] {
        ACT_NONE   = 2'h0,
        ACT_TOGGLE = 2'h1,
        ACT_CLEAR  = 2'h2,
        ACT_SET    = 2'h3
    } cmp_action_e;
    typedef logic [3:0] wave_mode_t;
endpackage : timer16_pkg

// >>> timer16_prescaler.sv
`timescale 1ns/1ps
`include "timer16_map.svh"
module timer16_prescaler
    import timer16_pkg::*;
#(
    parameter int DIV_WIDTH = 10
) (
    // Clock and reset
    input  wire logic     clk_in,
    input  wire logic     reset_n_in,
    // Source select and pin
    input  wire clk_sel_e clock_source_select_in,
    input  wire logic     external_count_pin_in,
    // Timer clock enable
    output logic          tick_out
);
    if (DIV_WIDTH != 10) begin : g_chk
        $error("DIV_WIDTH must be 10 for the /1024 tap");
    end

    logic [DIV_WIDTH-1:0] div_r;
    logic                 ext_prev_r;
    logic [DIV_WIDTH-1:0] div_mask;
    logic                 ext_rise;
    logic                 ext_fall;

    // Free running divider; shared by all prescaled taps
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            div_r      <= '0;
            ext_prev_r <= 1'b0;
        end else begin
            div_r      <= div_r + 1'b1;
            ext_prev_r <= external_count_pin_in;
        end
    end

    // Tap and edge selection
    assign div_mask = (clock_source_select_in == CS_DIV8)   ? `DIV_MASK_8 :
                      (clock_source_select_in == CS_DIV64)  ? `DIV_MASK_64 :
                      (clock_source_select_in == CS_DIV256) ? `DIV_MASK_256 :
                                                              `DIV_MASK_1024;
    assign ext_rise = external_count_pin_in && !ext_prev_r;
    assign ext_fall = !external_count_pin_in && ext_prev_r;

    always_comb begin
        unique case (clock_source_select_in)
            CS_STOP:     tick_out = 1'b0;
            CS_DIV1:     tick_out = 1'b1;
            CS_EXT_FALL: tick_out = ext_fall;
            CS_EXT_RISE: tick_out = ext_rise;
            default:     tick_out = ((div_r & div_mask) == div_mask);
        endcase
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    property p_ext_rise;
        (clock_source_select_in == CS_EXT_RISE) && external_count_pin_in
            && !ext_prev_r |-> tick_out;
    endproperty
    a_ext_rise: assert property (p_ext_rise) else $error("rising pin edge gave no tick");

    property p_ext_fall;
        (clock_source_select_in == CS_EXT_FALL) && external_count_pin_in
            ##1 (clock_source_select_in == CS_EXT_FALL) && !external_count_pin_in
            |-> tick_out;
    endproperty
    a_ext_fall: assert property (p_ext_fall) else $error("falling pin edge gave no tick");
endmodule : timer16_prescaler

// >>> timer16_pin_model.sv
`timescale 1ns/1ps
module timer16_pin_model (
    // Clock and commands
    input  wire logic clk_in,
    input  wire logic count_go_in,
    input  wire logic capture_go_in,
    // Pins into the timer
    output logic      external_count_pin_out,
    output logic      capture_input_pin_out
);
    logic [3:0] cnt_phase_r = 4'h0;
    logic [3:0] cap_phase_r = 4'h0;
    // Each go gives 3 cycles high, then 3 low, long enough for any synchroniser
    always_ff @(posedge clk_in) begin
        cnt_phase_r <= count_go_in ? 4'h6 : cnt_phase_r - {3'h0, cnt_phase_r != 4'h0};
        cap_phase_r <= capture_go_in ? 4'h6 : cap_phase_r - {3'h0, cap_phase_r != 4'h0};
    end
    // Pins rest low, so every pulse makes exactly one rise and one fall
    assign external_count_pin_out = cnt_phase_r > 4'h3;
    assign capture_input_pin_out  = cap_phase_r > 4'h3;
endmodule : timer16_pin_model

// >>> tb_timer16_counter_compare_capture.sv
`timescale 1ns/1ps
`include "timer16_map.svh"
module tb_timer16_counter_compare_capture;
    logic       clk_in     = 1'b0;
    logic       reset_n_in = 1'b0;
    logic       wr_in      = 1'b0;
    logic       rd_in      = 1'b0;
    logic       count_go   = 1'b0;
    logic       capture_go = 1'b0;
    logic       analog_cmp = 1'b0;
    logic [7:0] addr_in    = 8'h00;
    logic [7:0] wdata_in   = 8'h00;
    logic [7:0] rdata_out;
    logic       ext_pin;
    logic       cap_pin;
    logic       wave_a;
    logic       wave_b;
    logic       irq;
    int         fail_count = 0;
    int         checked    = 0;
    int         cycles     = 0;

    // Clock at 50 MHz
    always #10 clk_in = ~clk_in;

    timer16_core timer16_core_inst (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .external_count_pin_in(ext_pin), .capture_input_pin_in(cap_pin),
        .analog_comp_in(analog_cmp), .waveform_out_a(wave_a),
        .waveform_out_b(wave_b), .irq_out(irq)
    );
    timer16_pin_model timer16_pin_model_inst (
        .clk_in(clk_in), .count_go_in(count_go), .capture_go_in(capture_go),
        .external_count_pin_out(ext_pin), .capture_input_pin_out(cap_pin)
    );

    task automatic results();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    // Cut a hang short well past the few thousand cycles the run needs
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 8000) begin
            fail_count++;
            results();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Strobes stay up between back-to-back calls; idle drops them
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= 1'b1;
        rd_in    <= 1'b0;
        @(posedge clk_in);
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        addr_in <= a;
        wr_in   <= 1'b0;
        rd_in   <= 1'b1;
        @(posedge clk_in);
        rd_in   <= 1'b0;
        @(posedge clk_in);
        v = rdata_out;
    endtask : rd
    task automatic idle(input int n);
        wr_in <= 1'b0;
        rd_in <= 1'b0;
        repeat (n) @(posedge clk_in);
    endtask : idle
    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        wr(a + `OFS_HIGH, v[15:8]);
        wr(a, v[7:0]);
    endtask : wr16
    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        logic [7:0] lo;
        logic [7:0] hi;
        rd(a, lo);
        rd(a + `OFS_HIGH, hi);
        v = {hi, lo};
    endtask : rd16
    task automatic pulse(input logic cnt);
        count_go   <= cnt;
        capture_go <= ~cnt;
        @(posedge clk_in);
        count_go   <= 1'b0;
        capture_go <= 1'b0;
        repeat (8) @(posedge clk_in);
    endtask : pulse

    task automatic t_reset();
        logic [15:0] v;
        logic [7:0]  b;
        check({13'h0, irq, wave_a, wave_b}, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            rd16(`OFS_COUNT + 8'(2 * i), v);
            check(v, `RST_WORD);
        end
        rd(`OFS_CTRL_C, b);
        check({8'h00, b}, 16'h0000);
        wr(8'h80, 8'h5a);
        rd(8'h80, b);
        check({8'h00, b}, 16'h0000);
        idle(1);
    endtask : t_reset

    task automatic t_latch();
        logic [15:0] v;
        wr16(`OFS_CMP_A, 16'h1234);
        wr16(`OFS_CMP_B, 16'habcd);
        rd16(`OFS_CMP_A, v);
        check(v, 16'h1234);
        rd16(`OFS_CMP_B, v);
        check(v, 16'habcd);
        // Shared latch: the later high byte wins
        wr(`OFS_CMP_A + `OFS_HIGH, 8'h55);
        wr(`OFS_CMP_B + `OFS_HIGH, 8'h66);
        wr(`OFS_CMP_A, 8'h77);
        rd16(`OFS_CMP_A, v);
        check(v, 16'h6677);
        idle(1);
    endtask : t_latch

    task automatic t_ext();
        logic [15:0] v;
        logic [7:0]  sel [3] = '{8'h00, 8'h06, 8'h07};
        for (int s = 0; s < 3; s++) begin
            wr(`OFS_CTRL_B, sel[s]);
            wr16(`OFS_COUNT, 16'h0000);
            idle(2);
            repeat (3) pulse(1'b1);
            rd16(`OFS_COUNT, v);
            check(v, (s == 0) ? 16'h0000 : 16'h0003);
        end
        wr(`OFS_CTRL_B, 8'h00);
    endtask : t_ext

    // Any window of two divider periods holds exactly two ticks
    task automatic t_div();
        logic [15:0] v;
        logic [7:0]  sel [4] = '{8'h02, 8'h03, 8'h04, 8'h05};
        int          div [4] = '{8, 64, 256, 1024};
        for (int s = 0; s < 4; s++) begin
            wr(`OFS_CTRL_B, sel[s]);
            wr16(`OFS_COUNT, 16'h0000);
            idle(2 * div[s]);
            rd16(`OFS_COUNT, v);
            check(v, 16'h0002);
        end
        wr(`OFS_CTRL_B, 8'h00);
    endtask : t_div

    task automatic t_match();
        logic [7:0] b;
        wr(`OFS_CTRL_A, 8'h00);
        wr16(`OFS_CMP_A, 16'h0030);
        wr16(`OFS_CMP_B, 16'h0040);
        wr16(`OFS_COUNT, 16'h0030);
        wr(`OFS_STATUS, `STATUS_USED);
        wr(`OFS_CTRL_B, 8'h01);
        idle(30);
        rd(`OFS_STATUS, b);
        check({8'h00, b}, 16'h0004);
        check({15'h0, irq}, 16'h0000);
        wr(`OFS_MASK, 8'h04);
        idle(2);
        check({15'h0, irq}, 16'h0001);
        wr(`OFS_STATUS, 8'h04);
        wr(`OFS_CTRL_B, 8'h00);
        idle(2);
        check({15'h0, irq}, 16'h0000);
    endtask : t_match

    task automatic t_capture();
        logic [15:0] v;
        logic [7:0]  b;
        wr(`OFS_CTRL_B, 8'h40);
        wr16(`OFS_COUNT, 16'h0142);
        wr(`OFS_STATUS, `STATUS_USED);
        idle(2);
        pulse(1'b0);
        rd16(`OFS_CAPTURE, v);
        check(v, 16'h0142);
        rd(`OFS_STATUS, b);
        check({8'h00, b}, 16'h0020);
        // Comparator source, falling edge: the rise before it must not capture
        wr(`OFS_CTRL_B, 8'h20);
        wr16(`OFS_COUNT, 16'h0077);
        analog_cmp <= 1'b1;
        wr16(`OFS_COUNT, 16'h0066);
        analog_cmp <= 1'b0;
        idle(2);
        rd16(`OFS_CAPTURE, v);
        check(v, 16'h0066);
        // Capture as top: the pin must leave the register alone
        wr(`OFS_CTRL_B, 8'h58);
        wr16(`OFS_CAPTURE, 16'h0321);
        idle(2);
        pulse(1'b0);
        rd16(`OFS_CAPTURE, v);
        check(v, 16'h0321);
        wr(`OFS_CTRL_B, 8'h00);
    endtask : t_capture

    task automatic t_force();
        logic [15:0] v;
        logic [7:0]  b;
        wr(`OFS_CTRL_B, 8'h08);
        wr(`OFS_CTRL_A, 8'h50);
        wr16(`OFS_CMP_A, 16'h0003);
        wr16(`OFS_COUNT, 16'h0003);
        wr(`OFS_STATUS, `STATUS_USED);
        wr(`OFS_CTRL_C, 8'h80);
        idle(3);
        check({14'h0, wave_a, wave_b}, 16'h0002);
        wr(`OFS_CTRL_C, 8'h40);
        rd(`OFS_CTRL_C, b);
        check({8'h00, b}, 16'h0000);
        idle(3);
        check({14'h0, wave_a, wave_b}, 16'h0003);
        rd16(`OFS_COUNT, v);
        check(v, 16'h0003);
        rd(`OFS_STATUS, b);
        check({8'h00, b}, 16'h0000);
        // PWM mode: strobes must do nothing
        wr(`OFS_CTRL_A, 8'h51);
        wr(`OFS_CTRL_C, 8'hc0);
        idle(3);
        check({14'h0, wave_a, wave_b}, 16'h0003);
    endtask : t_force

    // Capture as top at 4: the counter wraps 0..4 and flags overflow
    task automatic t_top();
        logic [15:0] v;
        logic [7:0]  b;
        wr(`OFS_CTRL_A, 8'h00);
        wr16(`OFS_CAPTURE, 16'h0004);
        wr16(`OFS_COUNT, 16'h0000);
        wr(`OFS_STATUS, `STATUS_USED);
        wr(`OFS_CTRL_B, 8'h19);
        idle(12);
        rd16(`OFS_COUNT, v);
        check(v, 16'h0002);
        rd(`OFS_STATUS, b);
        check({8'h00, b}, 16'h0003);
        wr(`OFS_CTRL_B, 8'h00);
    endtask : t_top

    // Main sequence
    initial begin
        repeat (6) @(posedge clk_in);
        reset_n_in <= 1'b1;
        t_reset();
        t_latch();
        t_ext();
        t_div();
        t_match();
        t_capture();
        t_force();
        t_top();
        results();
    end
endmodule : tb_timer16_counter_compare_capture
